// ===== hdl/mram_rcvy_pkg.sv
// Functional notes
// (RQ1) start on software request or trigger pin
// (RQ2) first loader retry waits the minimum interval
// (RQ3) each later wait grows by minimum, capped
// (RQ4) capped wait reused until retries run out
// (RQ5) all loader retries failed: halt until power-up
// (RQ6) loader success always chains customer image recovery
// (RQ7) customer image tried twice, soft reset between
// (RQ8) back-off retries only for loader image
// (RQ9) recheck corrupt: loader again; second fail halts
// (RQ10) each bring-up step enabled or skipped separately
// (RQ11) power pin at polarity, 12-bit us/ms delay
// (RQ12) reset pin pulse of 10 us
// (RQ13) then device reset delay, own 12-bit field
// (RQ14) flash software reset command, same delay again
// (RQ15) preparatory commands sent on single lanes
// (RQ16) up to four preparatory commands
// (RQ17) after reading: reset, then power down
// (RQ18) all pins back to reset state afterwards
// (RQ19) status pin shows recovery in progress
// (RQ20) status: each image occurred, succeeded or failed
// (RQ21) status: image source, wired link UART or SPI
// (RQ22) status: reason code, one of four causes
// (RQ23) status: internal in-progress flag
// (RQ24) success count as 63-bit saturating bitcount
// (RQ25) retry state cleared only by power-on reset
package mram_rcvy_pkg;
	// timing
	localparam int CLK_MHZ = 10;
	localparam int US_CYC = CLK_MHZ;
	localparam int MS_US = 1000;
	localparam int RST_PULSE_US = 10;
	localparam int RST_PULSE_CYC = RST_PULSE_US * CLK_MHZ;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DELAY = 8'h04;
	localparam logic [7:0] OFF_RETRY = 8'h08;
	localparam logic [7:0] OFF_PRECMD = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_CNT0 = 8'h14;
	localparam logic [7:0] OFF_CNT1 = 8'h18;
	// reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [31:0] DELAY_RST = 32'h0000_0000;
	localparam logic [23:0] RETRY_RST = 24'h00_0000;
	localparam logic [31:0] PRECMD_RST = 32'h0000_0000;
	// control field positions
	localparam int C_EN = 0;
	localparam int C_SWREQ = 1;
	localparam int C_PINEN = 2;
	localparam int C_WIRED_V = 3;
	localparam int C_WIRED_C = 4;
	localparam int C_WIRED_SPI = 5;
	localparam int C_FLASH = 6;
	localparam int C_PWR_EN = 7;
	localparam int C_PWR_POL = 8;
	localparam int C_RST_EN = 9;
	localparam int C_RST_POL = 10;
	localparam int C_JEDEC_EN = 11;
	localparam int C_PRE_EN = 12;
	localparam int C_PRE_CNT = 13;
	// delay field positions
	localparam int D_PWR = 0;
	localparam int D_PWR_MS = 12;
	localparam int D_RST = 16;
	localparam int D_RST_MS = 28;
	// flash software reset sequence and preparatory command limit
	localparam logic [7:0] JEDEC_EN_BYTE = 8'h66;
	localparam logic [7:0] JEDEC_RST_BYTE = 8'h99;
	localparam logic [2:0] PRE_MAX = 3'h4;
	// recovery reasons
	localparam logic [1:0] WHY_LDR_CERT = 2'h0;
	localparam logic [1:0] WHY_CUST_CERT = 2'h1;
	localparam logic [1:0] WHY_PIN = 2'h2;
	localparam logic [1:0] WHY_SW = 2'h3;
	typedef enum logic [1:0] {U_CYC = 2'b00, U_US = 2'b01, U_MS = 2'b10} unit_t;
	typedef enum logic [3:0] {
		S_IDLE = 4'b0000, S_START = 4'b0001, S_PWR_WAIT = 4'b0010, S_RST_PULSE = 4'b0011,
		S_RST_WAIT = 4'b0100, S_JCMD = 4'b0101, S_J_WAIT = 4'b0110, S_PRE = 4'b0111,
		S_READ = 4'b1000, S_DN_RST = 4'b1001, S_DN_PWR = 4'b1010, S_DECIDE = 4'b1011,
		S_BACKOFF = 4'b1100, S_SOFTRST = 4'b1101, S_RECHECK = 4'b1110, S_HALT = 4'b1111
	} state_t;
endpackage

// ===== hdl/mram_recovery_sequencer.sv
`timescale 1ns/1ns
module mram_recovery_sequencer (
	// clock and power-on reset
	input wire logic core_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// corruption and trigger events
	input wire logic loaderCorrupt,
	input wire logic custCorrupt,
	input wire logic trigPin,
	// image reader handshake
	output logic readReq,
	output logic readImg,
	input wire logic readDone,
	input wire logic readOk,
	// internal soft reset and recheck
	output logic softRst,
	input wire logic recheckDone,
	input wire logic recheckCorrupt,
	// external device pins
	output logic pwrPinOut,
	output logic pwrPinOe,
	output logic rstPinOut,
	output logic rstPinOe,
	output logic spiCsN,
	output logic spiSck,
	output logic spiMosi,
	output logic spiOe,
	output logic statusPin
);
	mram_rcvy_pkg::state_t state;
	mram_rcvy_pkg::unit_t waitUnit;
	logic [15:0] ctrl_reg;
	logic [31:0] delay_reg;
	logic [23:0] retry_reg;
	logic [31:0] precmd_reg;
	logic swPend, trigPinPrev, curImg, lastOk, custTry;
	logic vendorOcc, vendorOk, custOcc, custOk, srcV, srcC;
	logic [1:0] reason;
	logic [7:0] retryUsed, curIv, nextIv;
	logic [8:0] ivSum;
	logic [11:0] waitCnt;
	logic [3:0] usPre;
	logic [9:0] msPre;
	logic preClr, usTick, msTick, tick;
	logic [1:0] cmdIdx;
	logic [2:0] preLast;
	logic [7:0] sendByte, shReg;
	logic [3:0] bitCnt;
	logic sendBusy, sendGo, sendDone, wired, pinEv, trigAny, preSkip;
	logic [62:0] cntBits;
	logic [31:0] rdMux;
	logic apbWr;

	// address decode shared by the read and write paths
	function automatic logic addrHit(input logic [7:0] a);
		return a == mram_rcvy_pkg::OFF_CTRL || a == mram_rcvy_pkg::OFF_DELAY ||
			a == mram_rcvy_pkg::OFF_RETRY || a == mram_rcvy_pkg::OFF_PRECMD ||
			a == mram_rcvy_pkg::OFF_STATUS || a == mram_rcvy_pkg::OFF_CNT0 ||
			a == mram_rcvy_pkg::OFF_CNT1;
	endfunction

	// event decode and back-off arithmetic
	assign pinEv = trigPin && !trigPinPrev && ctrl_reg[mram_rcvy_pkg::C_PINEN];
	assign trigAny = loaderCorrupt || custCorrupt || pinEv || swPend;
	assign wired = curImg ? ctrl_reg[mram_rcvy_pkg::C_WIRED_C] : ctrl_reg[mram_rcvy_pkg::C_WIRED_V];
	assign ivSum = {1'b0, curIv} + {1'b0, retry_reg[15:8]};
	assign preLast = (ctrl_reg[15:13] > mram_rcvy_pkg::PRE_MAX) ? 3'h3 : ctrl_reg[15:13] - 3'h1;
	assign preSkip = !ctrl_reg[mram_rcvy_pkg::C_FLASH] || !ctrl_reg[mram_rcvy_pkg::C_PRE_EN] ||
		ctrl_reg[15:13] == 3'h0; // RQ10
	assign apbWr = psel && penable && pready && pwrite;

	// first wait uses the minimum, then grows by it and sticks at the maximum
	always_comb begin
		if (retryUsed == 8'h00 || curIv == 8'h00) begin
			nextIv = retry_reg[15:8]; // RQ2
		end else if (ivSum >= {1'b0, retry_reg[23:16]}) begin
			nextIv = retry_reg[23:16]; // RQ4
		end else begin
			nextIv = ivSum[7:0]; // RQ3
		end
		if (nextIv > retry_reg[23:16]) begin
			nextIv = retry_reg[23:16];
		end
	end

	// prescalers restart at every us or ms wait load so no wait ends early
	always_ff @(posedge core_clk) begin
		if (rst || preClr) begin
			usPre <= 4'h0;
			msPre <= 10'h000;
		end else begin
			usPre <= usTick ? 4'h0 : usPre + 4'h1;
			if (usTick) begin
				msPre <= msTick ? 10'h000 : msPre + 10'h001;
			end
		end
	end
	assign usTick = usPre == 4'(mram_rcvy_pkg::US_CYC - 1);
	assign msTick = usTick && msPre == 10'(mram_rcvy_pkg::MS_US - 1);

	// unit-selected tick; a stale tick in the clearing cycle is ignored
	always_comb begin
		unique case (waitUnit)
			mram_rcvy_pkg::U_CYC: tick = 1'b1;
			mram_rcvy_pkg::U_US: tick = usTick && !preClr;
			mram_rcvy_pkg::U_MS: tick = msTick && !preClr;
			default: tick = 1'b0;
		endcase
	end

	// single-lane command shifter, mode 0, msb first
	assign sendGo = !sendBusy && (state == mram_rcvy_pkg::S_JCMD ||
		(state == mram_rcvy_pkg::S_PRE && !preSkip));
	assign sendDone = sendBusy && spiSck && bitCnt == 4'h1;
	always_comb begin
		if (state == mram_rcvy_pkg::S_JCMD) begin
			sendByte = (cmdIdx == 2'h0) ? mram_rcvy_pkg::JEDEC_EN_BYTE
				: mram_rcvy_pkg::JEDEC_RST_BYTE; // RQ14
		end else begin
			sendByte = precmd_reg[{cmdIdx, 3'b000} +: 8]; // RQ16
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sendBusy <= 1'b0;
			spiCsN <= 1'b1;
			spiSck <= 1'b0;
			spiMosi <= 1'b0;
			shReg <= 8'h00;
			bitCnt <= 4'h0;
		end else if (sendGo) begin
			sendBusy <= 1'b1; // RQ15
			spiCsN <= 1'b0;
			spiSck <= 1'b0;
			spiMosi <= sendByte[7];
			shReg <= sendByte;
			bitCnt <= 4'h8;
		end else if (sendBusy) begin
			spiSck <= !spiSck;
			if (spiSck) begin
				bitCnt <= bitCnt - 4'h1;
				shReg <= {shReg[6:0], 1'b0};
				spiMosi <= shReg[6];
				if (bitCnt == 4'h1) begin
					sendBusy <= 1'b0;
					spiCsN <= 1'b1;
					spiMosi <= 1'b0;
				end
			end
		end
	end

	// recovery sequencer; nothing here is touched by the internal soft reset
	always_ff @(posedge core_clk) begin
		readReq <= 1'b0;
		softRst <= 1'b0;
		preClr <= 1'b0;
		if (rst) begin
			state <= mram_rcvy_pkg::S_IDLE;
			waitUnit <= mram_rcvy_pkg::U_CYC;
			waitCnt <= 12'h000;
			retryUsed <= 8'h00; // RQ25
			curIv <= 8'h00; // RQ25
			curImg <= 1'b0;
			lastOk <= 1'b0;
			custTry <= 1'b0;
			cmdIdx <= 2'h0;
			{pwrPinOut, pwrPinOe, rstPinOut, rstPinOe, spiOe} <= 5'h00;
			{vendorOcc, vendorOk, custOcc, custOk, srcV, srcC} <= 6'h00;
			reason <= mram_rcvy_pkg::WHY_LDR_CERT;
			readImg <= 1'b0;
		end else begin
			if (waitCnt != 12'h000 && tick) begin
				waitCnt <= waitCnt - 12'h001;
			end
			unique case (state)
				mram_rcvy_pkg::S_IDLE: begin
					if (ctrl_reg[mram_rcvy_pkg::C_EN] && trigAny) begin
						state <= mram_rcvy_pkg::S_START; // RQ1
						custTry <= 1'b0;
						curImg <= !loaderCorrupt && custCorrupt;
						if (loaderCorrupt) begin
							reason <= mram_rcvy_pkg::WHY_LDR_CERT; // RQ22
						end else if (custCorrupt) begin
							reason <= mram_rcvy_pkg::WHY_CUST_CERT;
						end else if (pinEv) begin
							reason <= mram_rcvy_pkg::WHY_PIN;
						end else begin
							reason <= mram_rcvy_pkg::WHY_SW;
						end
					end
				end
				mram_rcvy_pkg::S_START: begin
					readImg <= curImg;
					if (wired) begin
						readReq <= 1'b1;
						state <= mram_rcvy_pkg::S_READ;
					end else begin
						spiOe <= ctrl_reg[mram_rcvy_pkg::C_FLASH];
						pwrPinOe <= ctrl_reg[mram_rcvy_pkg::C_PWR_EN]; // RQ11
						pwrPinOut <= ctrl_reg[mram_rcvy_pkg::C_PWR_EN] &&
							ctrl_reg[mram_rcvy_pkg::C_PWR_POL];
						waitCnt <= ctrl_reg[mram_rcvy_pkg::C_PWR_EN] ? delay_reg[11:0] : 12'h000;
						waitUnit <= delay_reg[mram_rcvy_pkg::D_PWR_MS] ? mram_rcvy_pkg::U_MS
							: mram_rcvy_pkg::U_US;
						preClr <= 1'b1;
						state <= mram_rcvy_pkg::S_PWR_WAIT;
					end
				end
				mram_rcvy_pkg::S_PWR_WAIT: begin
					if (waitCnt == 12'h000) begin
						if (ctrl_reg[mram_rcvy_pkg::C_RST_EN]) begin
							rstPinOe <= 1'b1; // RQ12
							rstPinOut <= ctrl_reg[mram_rcvy_pkg::C_RST_POL];
							waitCnt <= 12'(mram_rcvy_pkg::RST_PULSE_CYC - 1);
							waitUnit <= mram_rcvy_pkg::U_CYC;
							state <= mram_rcvy_pkg::S_RST_PULSE;
						end else begin
							state <= mram_rcvy_pkg::S_RST_WAIT; // RQ10
						end
					end
				end
				mram_rcvy_pkg::S_RST_PULSE: begin
					if (waitCnt == 12'h000) begin
						rstPinOut <= !ctrl_reg[mram_rcvy_pkg::C_RST_POL];
						waitCnt <= delay_reg[27:16]; // RQ13
						waitUnit <= delay_reg[mram_rcvy_pkg::D_RST_MS] ? mram_rcvy_pkg::U_MS
							: mram_rcvy_pkg::U_US;
						preClr <= 1'b1;
						state <= mram_rcvy_pkg::S_RST_WAIT;
					end
				end
				mram_rcvy_pkg::S_RST_WAIT: begin
					if (waitCnt == 12'h000) begin
						cmdIdx <= 2'h0;
						state <= (ctrl_reg[mram_rcvy_pkg::C_FLASH] &&
							ctrl_reg[mram_rcvy_pkg::C_JEDEC_EN]) ? mram_rcvy_pkg::S_JCMD
							: mram_rcvy_pkg::S_PRE; // RQ14
					end
				end
				mram_rcvy_pkg::S_JCMD: begin
					if (sendDone) begin
						cmdIdx <= cmdIdx + 2'h1;
						if (cmdIdx == 2'h1) begin
							cmdIdx <= 2'h0;
							waitCnt <= delay_reg[27:16]; // RQ14
							waitUnit <= delay_reg[mram_rcvy_pkg::D_RST_MS] ? mram_rcvy_pkg::U_MS
								: mram_rcvy_pkg::U_US;
							preClr <= 1'b1;
							state <= mram_rcvy_pkg::S_J_WAIT;
						end
					end
				end
				mram_rcvy_pkg::S_J_WAIT: begin
					if (waitCnt == 12'h000) begin
						state <= mram_rcvy_pkg::S_PRE;
					end
				end
				mram_rcvy_pkg::S_PRE: begin
					if (preSkip || (sendDone && {1'b0, cmdIdx} == preLast)) begin
						cmdIdx <= 2'h0;
						readReq <= 1'b1;
						state <= mram_rcvy_pkg::S_READ;
					end else if (sendDone) begin
						cmdIdx <= cmdIdx + 2'h1; // RQ16
					end
				end
				mram_rcvy_pkg::S_READ: begin
					if (readDone) begin
						lastOk <= readOk;
						if (wired) begin
							state <= mram_rcvy_pkg::S_DECIDE;
						end else if (ctrl_reg[mram_rcvy_pkg::C_RST_EN]) begin
							rstPinOut <= ctrl_reg[mram_rcvy_pkg::C_RST_POL]; // RQ17
							waitCnt <= 12'(mram_rcvy_pkg::RST_PULSE_CYC - 1);
							waitUnit <= mram_rcvy_pkg::U_CYC;
							state <= mram_rcvy_pkg::S_DN_RST;
						end else begin
							state <= mram_rcvy_pkg::S_DN_PWR;
						end
					end
				end
				mram_rcvy_pkg::S_DN_RST: begin
					// release reset here so the teardown pulse is as long as the bring-up one
					if (waitCnt == 12'h000) begin
						rstPinOut <= !ctrl_reg[mram_rcvy_pkg::C_RST_POL]; // RQ17
						state <= mram_rcvy_pkg::S_DN_PWR;
					end
				end
				mram_rcvy_pkg::S_DN_PWR: begin
					// power released last, in the same cycle as the reset pin and the spi output enable going back to their reset state
					{pwrPinOut, pwrPinOe, rstPinOut, rstPinOe, spiOe} <= 5'h00; // RQ17 RQ18
					state <= mram_rcvy_pkg::S_DECIDE;
				end
				mram_rcvy_pkg::S_DECIDE: begin
					if (!curImg) begin
						vendorOcc <= 1'b1; // RQ20
						vendorOk <= lastOk;
						srcV <= wired; // RQ21
						if (lastOk) begin
							curImg <= 1'b1; // RQ6
							state <= mram_rcvy_pkg::S_START;
						end else if (retryUsed < retry_reg[7:0]) begin
							retryUsed <= retryUsed + 8'h01; // RQ8
							curIv <= nextIv;
							waitCnt <= {4'h0, nextIv}; // RQ2 RQ3 RQ4
							waitUnit <= mram_rcvy_pkg::U_MS;
							preClr <= 1'b1;
							state <= mram_rcvy_pkg::S_BACKOFF;
						end else begin
							state <= mram_rcvy_pkg::S_HALT; // RQ5
						end
					end else begin
						custOcc <= 1'b1; // RQ20
						custOk <= lastOk;
						srcC <= wired; // RQ21
						if (lastOk) begin
							state <= mram_rcvy_pkg::S_IDLE;
						end else if (!custTry) begin
							custTry <= 1'b1; // RQ7
							state <= mram_rcvy_pkg::S_SOFTRST;
						end else begin
							state <= mram_rcvy_pkg::S_HALT; // RQ9
						end
					end
				end
				mram_rcvy_pkg::S_BACKOFF: begin
					if (waitCnt == 12'h000) begin
						state <= mram_rcvy_pkg::S_START;
					end
				end
				mram_rcvy_pkg::S_SOFTRST: begin
					softRst <= 1'b1; // RQ7
					state <= mram_rcvy_pkg::S_RECHECK;
				end
				mram_rcvy_pkg::S_RECHECK: begin
					if (recheckDone) begin
						curImg <= !recheckCorrupt; // RQ9
						state <= mram_rcvy_pkg::S_START;
					end
				end
				mram_rcvy_pkg::S_HALT: state <= mram_rcvy_pkg::S_HALT; // RQ5
			endcase
		end
	end

	// in-progress pin trails the sequencer by one cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			statusPin <= 1'b0;
			trigPinPrev <= 1'b0;
		end else begin
			statusPin <= state != mram_rcvy_pkg::S_IDLE && state != mram_rcvy_pkg::S_HALT; // RQ19
			trigPinPrev <= trigPin;
		end
	end

	// success bitcount fills from bit 0 upward and cannot wrap
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cntBits <= 63'h0;
		end else if (state == mram_rcvy_pkg::S_DECIDE && curImg && lastOk) begin
			cntBits <= {cntBits[61:0], 1'b1}; // RQ24
		end
	end

	// configuration registers; a pending request survives a same-cycle take
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_reg <= mram_rcvy_pkg::CTRL_RST;
			delay_reg <= mram_rcvy_pkg::DELAY_RST;
			retry_reg <= mram_rcvy_pkg::RETRY_RST;
			precmd_reg <= mram_rcvy_pkg::PRECMD_RST;
			swPend <= 1'b0;
		end else begin
			if (state == mram_rcvy_pkg::S_IDLE && ctrl_reg[mram_rcvy_pkg::C_EN]) begin
				swPend <= 1'b0;
			end
			if (apbWr && addrHit(paddr)) begin
				unique case (paddr)
					mram_rcvy_pkg::OFF_CTRL: begin
						ctrl_reg <= pwdata[15:0] & ~(16'h0001 << mram_rcvy_pkg::C_SWREQ);
						if (pwdata[mram_rcvy_pkg::C_SWREQ]) begin
							swPend <= 1'b1; // RQ1
						end
					end
					mram_rcvy_pkg::OFF_DELAY: delay_reg <= pwdata;
					mram_rcvy_pkg::OFF_RETRY: retry_reg <= pwdata[23:0];
					mram_rcvy_pkg::OFF_PRECMD: precmd_reg <= pwdata;
					default: ;
				endcase
			end
		end
	end

	// read mux; status shows the sequencer's own state
	always_comb begin
		rdMux = 32'h0000_0000;
		unique case (paddr)
			mram_rcvy_pkg::OFF_CTRL: rdMux = {16'h0000, ctrl_reg};
			mram_rcvy_pkg::OFF_DELAY: rdMux = delay_reg;
			mram_rcvy_pkg::OFF_RETRY: rdMux = {8'h00, retry_reg};
			mram_rcvy_pkg::OFF_PRECMD: rdMux = precmd_reg;
			mram_rcvy_pkg::OFF_STATUS: rdMux = {8'h00, retryUsed, 5'h00, state == mram_rcvy_pkg::S_HALT,
				statusPin, reason, ctrl_reg[mram_rcvy_pkg::C_WIRED_SPI], srcC, srcV,
				custOk, custOcc, vendorOk, vendorOcc}; // RQ20 RQ21 RQ22 RQ23
			mram_rcvy_pkg::OFF_CNT0: rdMux = cntBits[31:0];
			mram_rcvy_pkg::OFF_CNT1: rdMux = {1'b0, cntBits[62:32]};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// apb answer one cycle into the access phase
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addrHit(paddr);
			if (psel && penable && !pready) begin
				prdata <= pwrite ? 32'h0000_0000 : rdMux;
			end
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [7:0] pulseCnt;
	always_ff @(posedge core_clk) begin
		if (rst || state != mram_rcvy_pkg::S_RST_PULSE) begin
			pulseCnt <= 8'h00;
		end else begin
			pulseCnt <= pulseCnt + 8'h01;
		end
	end
	property p_start;
		state == mram_rcvy_pkg::S_IDLE && ctrl_reg[mram_rcvy_pkg::C_EN] && trigAny
			|=> state == mram_rcvy_pkg::S_START;
	endproperty
	a_start: assert property (p_start) else $error("trigger did not start recovery"); // RQ1
	property p_first_wait;
		state == mram_rcvy_pkg::S_DECIDE && !curImg && !lastOk && retryUsed == 8'h00 &&
			retry_reg[7:0] != 8'h00 && retry_reg[15:8] <= retry_reg[23:16]
			|=> state == mram_rcvy_pkg::S_BACKOFF && waitCnt == {4'h0, $past(retry_reg[15:8])};
	endproperty
	a_first_wait: assert property (p_first_wait) else $error("first wait not minimum"); // RQ2
	property p_grow;
		state == mram_rcvy_pkg::S_DECIDE && !curImg && !lastOk && retryUsed != 8'h00 &&
			curIv != 8'h00 && retryUsed < retry_reg[7:0] && ivSum < {1'b0, retry_reg[23:16]}
			|=> curIv == $past(curIv) + $past(retry_reg[15:8]);
	endproperty
	a_grow: assert property (p_grow) else $error("wait did not grow by minimum"); // RQ3
	property p_cap;
		state == mram_rcvy_pkg::S_DECIDE && !curImg && !lastOk && curIv == retry_reg[23:16] &&
			retryUsed != 8'h00 && retryUsed < retry_reg[7:0]
			|=> waitCnt == {4'h0, $past(retry_reg[23:16])};
	endproperty
	a_cap: assert property (p_cap) else $error("capped wait not held"); // RQ4
	property p_halt;
		state == mram_rcvy_pkg::S_HALT |=> state == mram_rcvy_pkg::S_HALT [*4];
	endproperty
	a_halt: assert property (p_halt) else $error("left halt without power cycle"); // RQ5
	property p_chain;
		state == mram_rcvy_pkg::S_DECIDE && !curImg && lastOk
			|=> curImg && state == mram_rcvy_pkg::S_START;
	endproperty
	a_chain: assert property (p_chain) else $error("customer image not chained"); // RQ6
	property p_soft;
		state == mram_rcvy_pkg::S_SOFTRST |=> softRst && custTry ##1 !softRst;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset not one pulse"); // RQ7
	property p_pulse;
		state == mram_rcvy_pkg::S_RST_PULSE && waitCnt == 12'h000
			|-> pulseCnt == 8'(mram_rcvy_pkg::RST_PULSE_CYC - 1) && rstPinOe;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse length wrong"); // RQ12
	property p_pins_home;
		state == mram_rcvy_pkg::S_DN_PWR |=> !pwrPinOe && !rstPinOe && !spiOe && !pwrPinOut;
	endproperty
	a_pins_home: assert property (p_pins_home) else $error("pins not released"); // RQ18
	property p_count;
		state == mram_rcvy_pkg::S_DECIDE && curImg && lastOk
			|=> cntBits == {$past(cntBits[61:0]), 1'b1};
	endproperty
	a_count: assert property (p_count) else $error("bitcount not advanced"); // RQ24
	property p_status_pin;
		##1 statusPin == ($past(state) != mram_rcvy_pkg::S_IDLE && $past(state) != mram_rcvy_pkg::S_HALT);
	endproperty
	a_status_pin: assert property (p_status_pin) else $error("status pin mismatch"); // RQ19
	c_backoff: cover property (state == mram_rcvy_pkg::S_BACKOFF && curIv == retry_reg[23:16]);
	c_chain: cover property (state == mram_rcvy_pkg::S_DECIDE && !curImg && lastOk);
	c_soft: cover property (state == mram_rcvy_pkg::S_RECHECK && recheckDone);
	c_halt: cover property (state == mram_rcvy_pkg::S_HALT);
endmodule

// ===== test/recovery_reader_model.sv
`timescale 1ns/1ns
module recovery_reader_model (
	// clock
	input wire logic core_clk,
	// image reader
	input wire logic readReq,
	input wire logic readImg,
	input wire logic vendOk,
	input wire logic custOk,
	input wire logic slow,
	output logic readDone,
	output logic readOk,
	// soft reset recheck
	input wire logic softRst,
	input wire logic chkBad,
	output logic recheckDone,
	output logic recheckCorrupt
);
	logic [7:0] rdPipe = 8'h00;
	logic [1:0] chkPipe = 2'h0;
	initial readDone = 0;
	initial readOk = 0;
	initial recheckDone = 0;
	initial recheckCorrupt = 0;
	// reader answers 3 or 9 cycles after the request; ok line toggles when not sampled
	always @(posedge core_clk) begin
		rdPipe <= {rdPipe[6:0], readReq};
		readDone <= slow ? rdPipe[7] : rdPipe[1];
		readOk <= (slow ? rdPipe[7] : rdPipe[1]) ? (readImg ? custOk : vendOk) : ~readOk;
	end
	// recheck answers after soft reset; its corrupt flag follows chkBad
	always @(posedge core_clk) begin
		chkPipe <= {chkPipe[0], softRst};
		recheckDone <= chkPipe[1];
		recheckCorrupt <= chkPipe[1] ? chkBad : ~recheckCorrupt;
	end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic core_clk = 0;
	logic rst = 1;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err;
	logic loaderCorrupt = 0, custCorrupt = 0, trigPin = 0, custOk = 1, slow = 0;
	logic vendOk = 1, chkBad = 0, sckPrev = 0;
	logic [47:0] spiBits = 48'h0;
	logic readReq, readImg, readDone, readOk, softRst, recheckDone, recheckCorrupt;
	logic pwrPinOut, pwrPinOe, rstPinOut, rstPinOe, spiCsN, spiSck, spiMosi, spiOe, statusPin;
	int errorCnt = 0, totalChecks = 0, pulseLen = 0, softCnt = 0;
	int vendReads = 0, statusCyc = 0, c0 = 0, spiCnt = 0;
	mram_recovery_sequencer dut_u (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .loaderCorrupt, .custCorrupt, .trigPin, .readReq, .readImg,
		.readDone, .readOk, .softRst, .recheckDone, .recheckCorrupt, .pwrPinOut, .pwrPinOe,
		.rstPinOut, .rstPinOe, .spiCsN, .spiSck, .spiMosi, .spiOe, .statusPin);
	recovery_reader_model peer_u (.core_clk, .readReq, .readImg, .vendOk, .custOk, .slow,
		.readDone, .readOk, .softRst, .chkBad, .recheckDone, .recheckCorrupt);
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		totalChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; holds the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do begin
			@(posedge core_clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (t >= 50) errorCnt++;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// one-cycle corruption event: 0 loader, 1 customer
	task automatic pulse(input logic cust);
		@(posedge core_clk);
		if (cust) custCorrupt <= 1;
		else loaderCorrupt <= 1;
		@(posedge core_clk);
		custCorrupt <= 0;
		loaderCorrupt <= 0;
	endtask
	// power cycle in mid-run; the only way out of halt
	task automatic restart();
		@(posedge core_clk);
		rst <= 1;
		repeat (8) @(posedge core_clk);
		rst <= 0;
	endtask
	// bounded wait for the status pin to rise and then fall
	task automatic waitFlow();
		int t;
		t = 0;
		while (statusPin !== 1'b1 && t < 20) begin
			@(posedge core_clk);
			t++;
		end
		while (statusPin !== 1'b0 && t < 95000) begin
			@(posedge core_clk);
			t++;
		end
		if (t >= 95000) errorCnt++;
	endtask
	// reset pin stretches must be exactly 10 us; power must already be on
	always @(posedge core_clk) begin
		if (rstPinOe === 1'b1 && rstPinOut === 1'b1) begin
			if (pulseLen == 0) cmp(pwrPinOe & pwrPinOut, 1);
			pulseLen++;
		end else if (pulseLen != 0) begin
			cmp(pulseLen, mram_rcvy_pkg::RST_PULSE_CYC);
			pulseLen = 0;
		end
		if (softRst === 1'b1) softCnt++;
		if (readReq === 1'b1 && readImg === 1'b0) vendReads++;
		if (statusPin === 1'b1) statusCyc++;
		// flash command bits taken on each rising serial clock while selected
		if (spiCsN === 1'b0 && spiSck === 1'b1 && sckPrev === 1'b0) begin
			spiBits = {spiBits[46:0], spiMosi};
			spiCnt++;
		end
		sckPrev = spiSck;
	end
	task automatic summarize();
		$display("checks=%0d errors=%0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#9600000;
		errorCnt++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 0;
		// reset values, read-only status, unmapped place
		for (int i = 0; i < 7; i++) begin
			apb(0, 8'(i * 4), 32'h0);
			cmp({err, rd}, 33'h0);
		end
		apb(1, mram_rcvy_pkg::OFF_STATUS, 32'hffff_ffff);
		apb(0, mram_rcvy_pkg::OFF_STATUS, 32'h0);
		cmp(rd, 32'h0);
		apb(0, 8'h1c, 32'h0);
		cmp({err, rd}, 33'h1_0000_0000);
		// wired loader recovery chains customer recovery
		apb(1, mram_rcvy_pkg::OFF_CTRL, 32'h0000_0019);
		pulse(0);
		waitFlow();
		apb(0, mram_rcvy_pkg::OFF_STATUS, 32'h0);
		cmp(rd, 32'h0000_003f);
		apb(0, mram_rcvy_pkg::OFF_CNT0, 32'h0);
		cmp(rd, 32'h0000_0001);
		// software request over spi, slow reader
		slow <= 1;
		apb(1, mram_rcvy_pkg::OFF_CTRL, 32'h0000_003b);
		waitFlow();
		apb(0, mram_rcvy_pkg::OFF_STATUS, 32'h0);
		cmp(rd, 32'h0000_01ff);
		// storage device bring-up by pin trigger, then teardown
		apb(1, mram_rcvy_pkg::OFF_DELAY, 32'h0003_0005);
		apb(1, mram_rcvy_pkg::OFF_PRECMD, 32'h4433_2211);
		apb(1, mram_rcvy_pkg::OFF_CTRL, 32'h0000_9fc5);
		@(posedge core_clk);
		trigPin <= 1;
		waitFlow();
		trigPin <= 0;
		cmp({pwrPinOe, rstPinOe, spiOe, pwrPinOut, rstPinOut, spiCsN}, 6'h01);
		apb(0, mram_rcvy_pkg::OFF_STATUS, 32'h0);
		cmp(rd[8:7], mram_rcvy_pkg::WHY_PIN);
		cmp(spiCnt, 96);
		cmp(spiBits[47:32], 16'h6699);
		cmp(spiBits[31:0], 32'h1122_3344);
		apb(0, mram_rcvy_pkg::OFF_CNT0, 32'h0);
		cmp(rd, 32'h0000_0007);
		// customer image fails twice: one soft reset, then halted
		custOk <= 0;
		apb(1, mram_rcvy_pkg::OFF_CTRL, 32'h0000_0019);
		pulse(1);
		waitFlow();
		cmp(softCnt, 1);
		apb(0, mram_rcvy_pkg::OFF_STATUS, 32'h0);
		cmp({rd[10], rd[8:7], rd[3]}, {1'b1, mram_rcvy_pkg::WHY_CUST_CERT, 1'b0});
		pulse(0);
		repeat (4) @(posedge core_clk);
		cmp(statusPin, 0);
		apb(0, mram_rcvy_pkg::OFF_CNT0, 32'h0);
		cmp(rd, 32'h0000_0007);
		// recheck finds corruption again: loader recovered once more, then halt
		restart();
		apb(0, mram_rcvy_pkg::OFF_STATUS, 32'h0);
		cmp(rd, 32'h0);
		chkBad <= 1;
		apb(1, mram_rcvy_pkg::OFF_CTRL, 32'h0000_0019);
		pulse(0);
		waitFlow();
		cmp(vendReads, 5);
		apb(0, mram_rcvy_pkg::OFF_STATUS, 32'h0);
		cmp(rd, 32'h0000_0437);
		// loader fails every time: waits of 1, 2, 3 and 3 ms, then halt
		restart();
		vendOk <= 0;
		apb(1, mram_rcvy_pkg::OFF_RETRY, 32'h0003_0104);
		apb(1, mram_rcvy_pkg::OFF_CTRL, 32'h0000_0019);
		c0 = statusCyc;
		pulse(0);
		waitFlow();
		cmp(vendReads, 10);
		cmp(statusCyc - c0 >= 90000 && statusCyc - c0 < 90200, 1);
		apb(0, mram_rcvy_pkg::OFF_STATUS, 32'h0);
		cmp(rd, 32'h0004_0411);
		summarize();
	end
endmodule
